// File: hdl/tvrt_map.svh
`ifndef TVRT_MAP_SVH
`define TVRT_MAP_SVH
// crt index slots of the selector/data pair
`define TVRT_CRT_INDEX 8'he0
`define TVRT_CRT_DATA 8'he1
// timing bank selector values
`define TVRT_R_VCNT_LO 8'h11
`define TVRT_R_LBUF_LO 8'h12
`define TVRT_R_VOVF3 8'h13
`define TVRT_R_F1_SO 8'h14
`define TVRT_R_F1_SE 8'h15
`define TVRT_R_F1_EO 8'h16
`define TVRT_R_F1_EE 8'h17
`define TVRT_R_F1_OVF 8'h18
`define TVRT_R_F2_SO 8'h19
`define TVRT_R_F2_SE 8'h1a
`define TVRT_R_F2_EO 8'h1b
`define TVRT_R_F2_EE 8'h1c
`define TVRT_R_F2_OVF 8'h1d
`define TVRT_R_HALF 8'h1e
`define TVRT_R_SLOPE 8'h1f
`define TVRT_R_HSLV_LO 8'h20
`define TVRT_R_VSTINI 8'h21
`define TVRT_R_HCYC_LO 8'h22
`define TVRT_R_HBS_LO 8'h23
`define TVRT_R_HOVF6 8'h24
`define TVRT_R_HBE_LO 8'h25
`define TVRT_R_HBLK_LO 8'h26
`define TVRT_R_HOVF7 8'h27
`define TVRT_R_HSS_LO 8'h28
`define TVRT_R_HSSH_LO 8'h29
`define TVRT_R_HOVF8 8'h2a
`define TVRT_R_X2S_LO 8'h2b
`define TVRT_R_X2E_LO 8'h2c
`define TVRT_R_HOVF9 8'h2d
`define TVRT_R_EQE_LO 8'h2e
`define TVRT_R_EQEH_LO 8'h2f
`define TVRT_R_HOVF10 8'h30
`define TVRT_R_SPE_LO 8'h31
`define TVRT_R_SPEH_LO 8'h32
`define TVRT_R_HOVF11 8'h33
`define TVRT_R_EXE_LO 8'h34
`define TVRT_R_EXEH_LO 8'h35
`define TVRT_R_HOVF12 8'h36
// bank extent
`define TVRT_FIRST 8'h11
`define TVRT_LAST 8'h36
`define TVRT_DEPTH 38
`define TVRT_NEVENTS 9
// reset and masks
`define TVRT_RST 8'h00
`define TVRT_FULL_MASK 8'hff
`define TVRT_VST_MASK 8'h1f
// field slices
`define TVRT_PAIR0 1:0
`define TVRT_PAIR1 3:2
`define TVRT_PAIR2 5:4
`define TVRT_PAIR3 7:6
`define TVRT_NIB_LO 3:0
`define TVRT_NIB_HI 7:4
`define TVRT_SLOPE_F 5:1
`define TVRT_VST_F 4:0
// single flag bits
`define TVRT_B_ACT_SO 7
`define TVRT_B_ACT_SE 6
`define TVRT_B_ACT_EO 5
`define TVRT_B_ACT_EE 4
`define TVRT_B_VSY_O 3
`define TVRT_B_EQ1_O 2
`define TVRT_B_EQ2_O 1
`define TVRT_B_VSY_E 0
`define TVRT_B_EQ1_E 7
`define TVRT_B_EQ2_E 6
`define TVRT_B_SLV8 0
// counter constants
`define TVRT_ZERO12 12'h000
`define TVRT_ONE12 12'h001
`endif

// File: hdl/tvrt_pkg.sv
package tvrt_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [9:0] line_t;
  typedef logic [11:0] pos_t;
endpackage : tvrt_pkg

// File: hdl/tvrt_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvrt_map.svh"
// positions from the register bank to the line timer, hits back
interface tvrt_if;
  tvrt_pkg::pos_t pos_full [`TVRT_NEVENTS];
  tvrt_pkg::pos_t pos_half [`TVRT_NEVENTS];
  tvrt_pkg::pos_t cycle_count;
  logic [`TVRT_NEVENTS-1:0] hit;
  tvrt_pkg::pos_t cnt;
  logic wrap;
  modport bank (output pos_full, output pos_half, output cycle_count,
    input hit, input cnt, input wrap);
  modport timer (input pos_full, input pos_half, input cycle_count,
    output hit, output cnt, output wrap);
endinterface : tvrt_if
`default_nettype wire

// File: hdl/tvrt_hcount.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvrt_map.svh"
module tvrt_hcount
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pix_en,
  input wire logic half_line_sel,
  tvrt_if.timer tim
);
  tvrt_pkg::pos_t cnt_reg;
  logic at_end;
  logic wrap_reg;
  logic [`TVRT_NEVENTS-1:0] hit_reg;

  // a zero count parks the counter instead of wrapping through 4095
  assign at_end = (tim.cycle_count == `TVRT_ZERO12) ||
    (cnt_reg >= tim.cycle_count - `TVRT_ONE12);

  // pixel counter, advanced only on pixel enable
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cnt_reg <= `TVRT_ZERO12;
    else if (pix_en)
      cnt_reg <= at_end ? `TVRT_ZERO12 : cnt_reg + `TVRT_ONE12;
  end

  // one-cycle line wrap marker
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wrap_reg <= 1'b0;
    else
      wrap_reg <= pix_en && at_end;
  end

  // one comparator per horizontal event; half variants on half-line lines
  for (genvar i = 0; i < `TVRT_NEVENTS; i++)
  begin : g_hit
    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
        hit_reg[i] <= 1'b0;
      else
        hit_reg[i] <= pix_en && (cnt_reg ==
          (half_line_sel ? tim.pos_half[i] : tim.pos_full[i]));
    end
  end

  assign tim.cnt = cnt_reg;
  assign tim.wrap = wrap_reg;
  assign tim.hit = hit_reg;
endmodule // tvrt_hcount
`default_nettype wire

// File: hdl/tvrt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvrt_map.svh"
module tvrt_top
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] crt_index,
  input wire logic crt_wr,
  input wire logic crt_rd,
  input wire logic [7:0] crt_wdata,
  output logic [7:0] crt_rdata,
  output logic crt_rvalid,
  input wire logic interlace_select,
  input wire logic field_even,
  input wire logic frame_two,
  input wire logic half_line_sel,
  input wire logic pix_en,
  output logic [9:0] vert_counter_init,
  output logic [9:0] line_buf_read_init,
  output logic [1:0] even_eq1_end_line_hi,
  output logic [1:0] even_eq2_end_line_hi,
  output logic [9:0] burst_line_start,
  output logic [9:0] burst_line_end,
  output logic active_start_at_line_begin,
  output logic active_end_at_line_end,
  output logic vsync_end_at_line_end,
  output logic eq1_end_at_line_end,
  output logic eq2_end_at_line_end,
  output logic [4:0] sync_expand_slope,
  output logic [8:0] hsync_level,
  output logic [4:0] vert_state_init,
  output logic [11:0] line_cycle_count,
  output logic [11:0] h_count,
  output logic line_start,
  output logic [8:0] h_event
);
  tvrt_pkg::byte_t bank [`TVRT_DEPTH];
  tvrt_pkg::byte_t sel_reg;
  logic [5:0] sel_slot;
  logic sel_in_bank;
  logic index_wr;
  logic data_wr;
  logic use_even;
  tvrt_pkg::byte_t vovf3;
  tvrt_pkg::byte_t f1_ovf;
  tvrt_pkg::byte_t f2_ovf;
  tvrt_pkg::byte_t half_flags;
  tvrt_pkg::byte_t slope_reg;
  tvrt_pkg::byte_t vst_byte;
  tvrt_pkg::byte_t hovf6;
  tvrt_pkg::byte_t hovf7;
  tvrt_pkg::byte_t hovf8;
  tvrt_pkg::byte_t hovf9;
  tvrt_pkg::byte_t hovf10;
  tvrt_pkg::byte_t hovf11;
  tvrt_pkg::byte_t hovf12;
  tvrt_pkg::line_t f1_burst_start_odd;
  tvrt_pkg::line_t f1_burst_start_even;
  tvrt_pkg::line_t f1_burst_end_odd;
  tvrt_pkg::line_t f1_burst_end_even;
  tvrt_pkg::line_t f2_burst_start_odd;
  tvrt_pkg::line_t f2_burst_start_even;
  tvrt_pkg::line_t f2_burst_end_odd;
  tvrt_pkg::line_t f2_burst_end_even;
  tvrt_pkg::pos_t line_cycle_next;
  tvrt_pkg::pos_t h_burst_start;
  tvrt_pkg::pos_t h_burst_end;
  tvrt_pkg::pos_t h_blank_end;
  tvrt_pkg::pos_t hsync_start_full;
  tvrt_pkg::pos_t hsync_start_half;
  tvrt_pkg::pos_t sync_exp2_start;
  tvrt_pkg::pos_t sync_exp2_end;
  tvrt_pkg::pos_t eq_pulse_end_full;
  tvrt_pkg::pos_t eq_pulse_end_half;
  tvrt_pkg::pos_t sync_pulse_end_full;
  tvrt_pkg::pos_t sync_pulse_end_half;
  tvrt_pkg::pos_t eq_sync_exp2_end_full;
  tvrt_pkg::pos_t eq_sync_exp2_end_half;

  tvrt_if tim_if ();

  // bank lookup by selector value; callers pass only mapped offsets
  function automatic tvrt_pkg::byte_t rg(input logic [7:0] off);
    rg = bank[6'(off - `TVRT_FIRST)];
  endfunction

  // selector/data pair decode
  assign index_wr = crt_wr && (crt_index == `TVRT_CRT_INDEX);
  assign data_wr = crt_wr && (crt_index == `TVRT_CRT_DATA);
  assign sel_in_bank = (sel_reg >= `TVRT_FIRST) && (sel_reg <= `TVRT_LAST);
  assign sel_slot = 6'(sel_reg - `TVRT_FIRST);

  // selector slot; data accesses go wherever it last pointed
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sel_reg <= `TVRT_RST;
    else if (index_wr)
      sel_reg <= crt_wdata;
  end

  // one storage byte per selector value; writes outside the bank are dropped
  // an unmapped selector writes nothing, so no stray byte can alias into the bank
  for (genvar i = 0; i < `TVRT_DEPTH; i++)
  begin : g_bank
    // reserved bits are never stored, so they always read back as zero
    localparam tvrt_pkg::byte_t WMASK =
      (8'(i) + `TVRT_FIRST == `TVRT_R_VSTINI) ? `TVRT_VST_MASK : `TVRT_FULL_MASK;
    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
        bank[i] <= `TVRT_RST;
      else if (data_wr && sel_in_bank && (sel_slot == 6'(i)))
        bank[i] <= crt_wdata & WMASK;
    end
  end

  // read answer one cycle after the strobe; other crt indices answer nothing
  // the selector reads back as well, so software can save and restore it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      crt_rdata <= `TVRT_RST;
      crt_rvalid <= 1'b0;
    end
    else
    begin
      crt_rvalid <= crt_rd &&
        ((crt_index == `TVRT_CRT_INDEX) || (crt_index == `TVRT_CRT_DATA));
      if (crt_rd && (crt_index == `TVRT_CRT_INDEX))
        crt_rdata <= sel_reg;
      else if (crt_rd && (crt_index == `TVRT_CRT_DATA))
        crt_rdata <= sel_in_bank ? bank[sel_slot] : `TVRT_RST;
      else
        crt_rdata <= `TVRT_RST;
    end
  end

  // shared overflow and flag bytes, then the wide values built from them;
  // a process rather than plain assigns, because an assign would not wake up
  // on bank writes that it only sees through the lookup function
  always_comb
  begin
    vovf3 = rg(`TVRT_R_VOVF3);
    f1_ovf = rg(`TVRT_R_F1_OVF);
    f2_ovf = rg(`TVRT_R_F2_OVF);
    half_flags = rg(`TVRT_R_HALF);
    slope_reg = rg(`TVRT_R_SLOPE);
    vst_byte = rg(`TVRT_R_VSTINI);
    hovf6 = rg(`TVRT_R_HOVF6);
    hovf7 = rg(`TVRT_R_HOVF7);
    hovf8 = rg(`TVRT_R_HOVF8);
    hovf9 = rg(`TVRT_R_HOVF9);
    hovf10 = rg(`TVRT_R_HOVF10);
    hovf11 = rg(`TVRT_R_HOVF11);
    hovf12 = rg(`TVRT_R_HOVF12);

    // frame 1 burst lines: overflow pair above each low byte
    f1_burst_start_odd = {f1_ovf[`TVRT_PAIR0], rg(`TVRT_R_F1_SO)};
    f1_burst_start_even = {f1_ovf[`TVRT_PAIR1], rg(`TVRT_R_F1_SE)};
    f1_burst_end_odd = {f1_ovf[`TVRT_PAIR2], rg(`TVRT_R_F1_EO)};
    f1_burst_end_even = {f1_ovf[`TVRT_PAIR3], rg(`TVRT_R_F1_EE)};

    // frame 2 burst lines, same pair order
    f2_burst_start_odd = {f2_ovf[`TVRT_PAIR0], rg(`TVRT_R_F2_SO)};
    f2_burst_start_even = {f2_ovf[`TVRT_PAIR1], rg(`TVRT_R_F2_SE)};
    f2_burst_end_odd = {f2_ovf[`TVRT_PAIR2], rg(`TVRT_R_F2_EO)};
    f2_burst_end_even = {f2_ovf[`TVRT_PAIR3], rg(`TVRT_R_F2_EE)};

    // twelve-bit horizontal positions, nibble above low byte
    line_cycle_next = {hovf6[`TVRT_NIB_LO], rg(`TVRT_R_HCYC_LO)};
    h_burst_start = {hovf6[`TVRT_NIB_HI], rg(`TVRT_R_HBS_LO)};
    // overflow6 low nibble is the cycle count, so burst end must use overflow7
    h_burst_end = {hovf7[`TVRT_NIB_LO], rg(`TVRT_R_HBE_LO)};
    h_blank_end = {hovf7[`TVRT_NIB_HI], rg(`TVRT_R_HBLK_LO)};
    hsync_start_full = {hovf8[`TVRT_NIB_LO], rg(`TVRT_R_HSS_LO)};
    hsync_start_half = {hovf8[`TVRT_NIB_HI], rg(`TVRT_R_HSSH_LO)};
    sync_exp2_start = {hovf9[`TVRT_NIB_LO], rg(`TVRT_R_X2S_LO)};
    sync_exp2_end = {hovf9[`TVRT_NIB_HI], rg(`TVRT_R_X2E_LO)};
    eq_pulse_end_full = {hovf10[`TVRT_NIB_LO], rg(`TVRT_R_EQE_LO)};
    eq_pulse_end_half = {hovf10[`TVRT_NIB_HI], rg(`TVRT_R_EQEH_LO)};
    sync_pulse_end_full = {hovf11[`TVRT_NIB_LO], rg(`TVRT_R_SPE_LO)};
    sync_pulse_end_half = {hovf11[`TVRT_NIB_HI], rg(`TVRT_R_SPEH_LO)};
    eq_sync_exp2_end_full = {hovf12[`TVRT_NIB_LO], rg(`TVRT_R_EXE_LO)};
    eq_sync_exp2_end_half = {hovf12[`TVRT_NIB_HI], rg(`TVRT_R_EXEH_LO)};
  end

  // event slots for the line timer; events without a half variant repeat the full one
  // the half column only takes effect on lines flagged by half_line_sel
  assign tim_if.cycle_count = line_cycle_next;
  assign tim_if.pos_full[0] = h_burst_start;
  assign tim_if.pos_full[1] = h_burst_end;
  assign tim_if.pos_full[2] = h_blank_end;
  assign tim_if.pos_full[3] = hsync_start_full;
  assign tim_if.pos_full[4] = sync_exp2_start;
  assign tim_if.pos_full[5] = sync_exp2_end;
  assign tim_if.pos_full[6] = eq_pulse_end_full;
  assign tim_if.pos_full[7] = sync_pulse_end_full;
  assign tim_if.pos_full[8] = eq_sync_exp2_end_full;
  assign tim_if.pos_half[0] = h_burst_start;
  assign tim_if.pos_half[1] = h_burst_end;
  assign tim_if.pos_half[2] = h_blank_end;
  assign tim_if.pos_half[3] = hsync_start_half;
  assign tim_if.pos_half[4] = sync_exp2_start;
  assign tim_if.pos_half[5] = sync_exp2_end;
  assign tim_if.pos_half[6] = eq_pulse_end_half;
  assign tim_if.pos_half[7] = sync_pulse_end_half;
  assign tim_if.pos_half[8] = eq_sync_exp2_end_half;

  // progressive scan always runs odd-line timing
  // field_even alone never picks even values, so a stale field flag is harmless
  assign use_even = interlace_select && field_even;

  // vertical set-up values staged into flops
  // staging costs a cycle of latency but keeps every data output a flop
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      vert_counter_init <= {`TVRT_RST, 2'h0};
      line_buf_read_init <= {`TVRT_RST, 2'h0};
      even_eq1_end_line_hi <= 2'h0;
      even_eq2_end_line_hi <= 2'h0;
      vert_state_init <= 5'h00;
    end
    else
    begin
      vert_counter_init <= {vovf3[`TVRT_PAIR2], rg(`TVRT_R_VCNT_LO)};
      line_buf_read_init <= {vovf3[`TVRT_PAIR3], rg(`TVRT_R_LBUF_LO)};
      even_eq1_end_line_hi <= vovf3[`TVRT_PAIR0];
      even_eq2_end_line_hi <= vovf3[`TVRT_PAIR1];
      vert_state_init <= vst_byte[`TVRT_VST_F];
    end
  end

  // burst line window for the current frame and field
  // frame_two picks the frame, use_even the field within it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      burst_line_start <= {`TVRT_RST, 2'h0};
      burst_line_end <= {`TVRT_RST, 2'h0};
    end
    else if (frame_two)
    begin
      burst_line_start <= use_even ? f2_burst_start_even : f2_burst_start_odd;
      burst_line_end <= use_even ? f2_burst_end_even : f2_burst_end_odd;
    end
    else
    begin
      burst_line_start <= use_even ? f1_burst_start_even : f1_burst_start_odd;
      burst_line_end <= use_even ? f1_burst_end_even : f1_burst_end_odd;
    end
  end

  // half-line placement flags resolved for the current field
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      active_start_at_line_begin <= 1'b0;
      active_end_at_line_end <= 1'b0;
      vsync_end_at_line_end <= 1'b0;
      eq1_end_at_line_end <= 1'b0;
      eq2_end_at_line_end <= 1'b0;
    end
    else
    begin
      active_start_at_line_begin <= use_even ?
        half_flags[`TVRT_B_ACT_SE] : half_flags[`TVRT_B_ACT_SO];
      active_end_at_line_end <= use_even ?
        half_flags[`TVRT_B_ACT_EE] : half_flags[`TVRT_B_ACT_EO];
      vsync_end_at_line_end <= use_even ?
        half_flags[`TVRT_B_VSY_E] : half_flags[`TVRT_B_VSY_O];
      eq1_end_at_line_end <= use_even ?
        slope_reg[`TVRT_B_EQ1_E] : half_flags[`TVRT_B_EQ1_O];
      eq2_end_at_line_end <= use_even ?
        slope_reg[`TVRT_B_EQ2_E] : half_flags[`TVRT_B_EQ2_O];
    end
  end

  // sync shaping and line length staged into flops
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync_expand_slope <= 5'h00;
      hsync_level <= 9'h000;
      line_cycle_count <= `TVRT_ZERO12;
    end
    else
    begin
      sync_expand_slope <= slope_reg[`TVRT_SLOPE_F];
      hsync_level <= {slope_reg[`TVRT_B_SLV8], rg(`TVRT_R_HSLV_LO)};
      line_cycle_count <= line_cycle_next;
    end
  end

  // horizontal line timer
  // its comparators are flops, so h_event trails the matching count by one cycle
  tvrt_hcount tvrt_hcount_inst
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pix_en(pix_en),
    .half_line_sel(half_line_sel),
    .tim(tim_if.timer)
  );

  // timer results are already flops inside the timer
  // no extra stage here, so line_start rises as h_count returns to zero and h_event trails its matching count by one cycle
  assign h_count = tim_if.cnt;
  assign line_start = tim_if.wrap;
  assign h_event = tim_if.hit;
endmodule // tvrt_top
`default_nettype wire

// File: dv/tvrt_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvrt_map.svh"
module tvrt_top_checker
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] crt_index,
  input wire logic crt_wr,
  input wire logic crt_rd,
  input wire logic [7:0] crt_wdata,
  input wire logic [7:0] crt_rdata,
  input wire logic crt_rvalid,
  input wire logic pix_en,
  input wire logic [9:0] vert_counter_init,
  input wire logic [9:0] line_buf_read_init,
  input wire logic [4:0] sync_expand_slope,
  input wire logic [8:0] hsync_level,
  input wire logic [4:0] vert_state_init,
  input wire logic [11:0] line_cycle_count,
  input wire logic [11:0] h_count,
  input wire logic line_start,
  input wire logic [8:0] h_event
);
  logic [7:0] sel_reg;
  logic hit;
  logic dwr;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // shadow selector, so a data write can be tied to the register it lands in
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sel_reg <= 8'h00;
    else if (crt_wr && crt_index == `TVRT_CRT_INDEX)
      sel_reg <= crt_wdata;
  end
  // decoded strobes of the index/data pair
  assign hit = crt_rd && (crt_index == `TVRT_CRT_INDEX || crt_index == `TVRT_CRT_DATA);
  assign dwr = crt_wr && crt_index == `TVRT_CRT_DATA;
  chk_read_answer: assert property (
    hit |=> crt_rvalid) else $error("read strobe got no answer");
  chk_no_stray_valid: assert property (
    !hit |=> !crt_rvalid && crt_rdata == 8'h00) else $error("answer without a read");
  chk_slope_level_split: assert property (
    dwr && sel_reg == `TVRT_R_SLOPE |-> ##2 sync_expand_slope == $past(crt_wdata[5:1], 2)
    && hsync_level[8] == $past(crt_wdata[0], 2)) else $error("slope/level split wrong");
  chk_cycle_low_byte: assert property (
    dwr && sel_reg == `TVRT_R_HCYC_LO |-> ##2 line_cycle_count[7:0] == $past(crt_wdata, 2))
    else $error("cycle count low byte not taken");
  chk_vstate_field: assert property (
    dwr && sel_reg == `TVRT_R_VSTINI |-> ##2 vert_state_init == $past(crt_wdata[4:0], 2))
    else $error("vertical state field wrong");
  chk_ovf3_upper_pairs: assert property (
    dwr && sel_reg == `TVRT_R_VOVF3 |-> ##2 vert_counter_init[9:8] == $past(crt_wdata[5:4], 2)
    && line_buf_read_init[9:8] == $past(crt_wdata[7:6], 2))
    else $error("overflow pairs wrong");
  chk_line_wrap: assert property (
    pix_en && line_cycle_count != 12'h000 && h_count == line_cycle_count - 12'h001
    |=> line_start && h_count == 12'h000) else $error("counter did not wrap");
  chk_idle_hold: assert property (
    !pix_en |=> $stable(h_count) && h_event == 9'h000 && !line_start)
    else $error("timer moved without pixel enable");
  cov_read: cover property (hit ##1 crt_rvalid);
  cov_line: cover property (line_start);
  cov_hsync: cover property (h_event[3]);
endmodule // tvrt_top_checker
bind tvrt_top tvrt_top_checker tvrt_top_checker_inst (.clk_sys, .sys_rst, .crt_index,
  .crt_wr, .crt_rd, .crt_wdata, .crt_rdata, .crt_rvalid, .pix_en, .vert_counter_init,
  .line_buf_read_init, .sync_expand_slope, .hsync_level, .vert_state_init,
  .line_cycle_count, .h_count, .line_start, .h_event);
`default_nettype wire

// File: dv/tvrt_tv_model.sv
`timescale 1ns/1ps
`default_nettype none
module tvrt_tv_model
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic run,
  output logic pix_en,
  input wire logic line_start,
  output logic [15:0] lines
);
  // pixel pacing, gated so the bench can stall the line mid-way
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pix_en <= 1'b0;
    else
      pix_en <= run;
  end
  // lines seen by the encoder side
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lines <= 16'h0000;
    else if (line_start)
      lines <= lines + 16'h0001;
  end
endmodule // tvrt_tv_model
`default_nettype wire

// File: dv/tvrt_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvrt_map.svh"
module tvrt_top_test;
  logic clk_sys, sys_rst, crt_wr, crt_rd, crt_rvalid, run, pix_en, line_start;
  logic interlace_select, field_even, frame_two, half_line_sel;
  logic [7:0] crt_index, crt_wdata, crt_rdata;
  logic [9:0] vert_counter_init, line_buf_read_init, burst_line_start, burst_line_end;
  logic [1:0] even_eq1_end_line_hi, even_eq2_end_line_hi;
  logic active_start_at_line_begin, active_end_at_line_end, vsync_end_at_line_end;
  logic eq1_end_at_line_end, eq2_end_at_line_end;
  logic [4:0] sync_expand_slope, vert_state_init;
  logic [8:0] hsync_level, h_event;
  logic [11:0] line_cycle_count, h_count;
  logic [15:0] lines;
  logic [7:0] mem [0:255];
  int errors = 0;
  int checks_done = 0;
  tvrt_top tvrt_top_inst (.clk_sys, .sys_rst, .crt_index, .crt_wr, .crt_rd, .crt_wdata,
    .crt_rdata, .crt_rvalid, .interlace_select, .field_even, .frame_two, .half_line_sel,
    .pix_en, .vert_counter_init, .line_buf_read_init, .even_eq1_end_line_hi,
    .even_eq2_end_line_hi, .burst_line_start, .burst_line_end, .active_start_at_line_begin,
    .active_end_at_line_end, .vsync_end_at_line_end, .eq1_end_at_line_end,
    .eq2_end_at_line_end, .sync_expand_slope, .hsync_level, .vert_state_init,
    .line_cycle_count, .h_count, .line_start, .h_event);
  tvrt_tv_model tvrt_tv_model_inst (.clk_sys, .sys_rst, .run, .pix_en, .line_start, .lines);
  // 100 ns period
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one strobe on the pair; the idle cycle after it keeps strobes from colliding
  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    crt_index <= idx;
    crt_wr <= 1'b1;
    crt_wdata <= d;
    @(posedge clk_sys);
    crt_wr <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(`TVRT_CRT_INDEX, a);
    put(`TVRT_CRT_DATA, d);
    mem[a] = (a == `TVRT_R_VSTINI) ? (d & `TVRT_VST_MASK) : d;
  endtask
  // answer stands only in the cycle after the strobe, so it is sampled there
  task automatic get(input logic [7:0] idx, input logic [7:0] exp, input logic ev);
    @(posedge clk_sys);
    crt_index <= idx;
    crt_rd <= 1'b1;
    @(posedge clk_sys);
    crt_rd <= 1'b0;
    #1;
    chk(crt_rvalid, ev);
    chk(crt_rdata, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    logic ev, pe, hs;
    logic [7:0] b, o, h, s;
    logic [11:0] pc, nx;
    int nl;
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {crt_wr, crt_rd, run, interlace_select, field_even, frame_two, half_line_sel} = '0;
    crt_index = 8'h00;
    crt_wdata = 8'h00;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // every bank byte starts at zero, then holds a distinct pattern
    for (int a = 'h11; a <= 'h36; a++)
    begin
      put(`TVRT_CRT_INDEX, 8'(a));
      get(`TVRT_CRT_DATA, 8'h00, 1'b1);
    end
    for (int a = 'h11; a <= 'h36; a++)
    begin
      wr(8'(a), 8'(a) ^ 8'ha5);
      get(`TVRT_CRT_DATA, mem[a], 1'b1);
    end
    // selector outside the bank: write dropped, read answers zero
    wr(8'h40, 8'h77);
    get(`TVRT_CRT_INDEX, 8'h40, 1'b1);
    get(`TVRT_CRT_DATA, 8'h00, 1'b1);
    get(8'h10, 8'h00, 1'b0);
    chk(vert_counter_init, {mem[8'h13][5:4], mem[8'h11]});
    chk(line_buf_read_init, {mem[8'h13][7:6], mem[8'h12]});
    chk({even_eq2_end_line_hi, even_eq1_end_line_hi}, mem[8'h13][3:0]);
    chk(sync_expand_slope, mem[8'h1f][5:1]);
    chk(hsync_level, {mem[8'h1f][0], mem[8'h20]});
    chk(vert_state_init, mem[8'h21][4:0]);
    chk(line_cycle_count, {mem[8'h24][3:0], mem[8'h22]});
    // all frame, field and scan combinations
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk_sys);
      interlace_select <= k[0];
      field_even <= k[1];
      frame_two <= k[2];
      repeat (2) @(posedge clk_sys);
      #1;
      ev = k[0] & k[1];
      b = k[2] ? 8'h19 : 8'h14;
      o = mem[b + 8'h04];
      h = mem[8'h1e];
      s = mem[8'h1f];
      chk(burst_line_start, ev ? {o[3:2], mem[b + 8'h01]} : {o[1:0], mem[b]});
      chk(burst_line_end, ev ? {o[7:6], mem[b + 8'h03]} : {o[5:4], mem[b + 8'h02]});
      chk(active_start_at_line_begin, ev ? h[6] : h[7]);
      chk(active_end_at_line_end, ev ? h[4] : h[5]);
      chk(vsync_end_at_line_end, ev ? h[0] : h[3]);
      chk({eq1_end_at_line_end, eq2_end_at_line_end}, ev ? s[7:6] : h[2:1]);
    end
    // three-pixel line with burst start at 1 and hsync at 2 (half line: 0)
    wr(8'h24, 8'h00);
    wr(8'h22, 8'h03);
    wr(8'h23, 8'h01);
    // blank end at 0; burst end nibble sits in overflow7, putting it out of reach
    wr(8'h25, 8'h00);
    wr(8'h26, 8'h00);
    wr(8'h27, 8'h01);
    wr(8'h2a, 8'h00);
    wr(8'h28, 8'h02);
    wr(8'h29, 8'h00);
    nl = 0;
    for (int i = 0; i < 24; i++)
    begin
      @(negedge clk_sys);
      pc = h_count;
      pe = pix_en;
      hs = half_line_sel;
      @(posedge clk_sys);
      run <= (i % 5 != 3);
      half_line_sel <= (i >= 12);
      #1;
      nx = (pc >= 12'h002) ? 12'h000 : pc + 12'h001;
      chk(h_count, pe ? nx : pc);
      chk(line_start, pe && pc == 12'h002);
      chk(h_event[0], pe && pc == 12'h001);
      chk(h_event[3], pe && pc == (hs ? 12'h000 : 12'h002));
      chk(h_event[2], pe && pc == 12'h000);
      chk({h_event[8:4], h_event[1]}, 12'h000);
      nl += int'(pe && pc == 12'h002);
    end
    @(posedge clk_sys);
    #1;
    chk(lines[11:0], 12'(nl));
    tally_and_finish();
  end
endmodule // tvrt_top_test
`default_nettype wire
